// ==== shared/rsi_pkg.sv ====
package rsi_pkg;
	// reset acceptance
	localparam int          RST_MIN_CYC    = 10;
	// reset vector byte addresses
	localparam logic [23:0] VEC_ADDR_LO    = 24'hFFFF00;
	localparam logic [23:0] VEC_ADDR_MID   = 24'hFFFF01;
	localparam logic [23:0] VEC_ADDR_HI    = 24'hFFFF02;
	// core values after acceptance
	localparam logic [31:0] SP_RESET       = 32'h00000100;
	localparam logic [2:0]  MASK_RESET     = 3'h7;
	localparam logic        MAXMODE_RESET  = 1'h1;
	localparam logic [2:0]  BANK_RESET     = 3'h0;
	// clock gear codes, reset value is divide by two
	localparam logic [2:0]  GEAR_DIV1      = 3'h0;
	localparam logic [2:0]  GEAR_DIV2      = 3'h1;
	localparam logic [2:0]  GEAR_DIV4      = 3'h2;
	localparam logic [2:0]  GEAR_DIV8      = 3'h3;
	localparam logic [2:0]  GEAR_DIV16     = 3'h4;
	localparam logic [2:0]  GEAR_RESET     = 3'h1;
	localparam logic [3:0]  DIV_CNT_RESET  = 4'h0;

	typedef enum logic [1:0] {
		RSI_NMI_FALL,
		RSI_NMI_BOTH
	} rsi_nmi_mode_t;

	// status word fields
	typedef struct packed {
		logic       max_mode;
		logic [2:0] irq_mask_level;
		logic [2:0] reg_bank_pointer;
	} rsi_status_word_t;

	// clock configuration from software
	typedef struct packed {
		logic       sys_clock_select;
		logic [2:0] clock_gear_field;
	} rsi_clk_cfg_t;
endpackage

// ==== rtl/rsi_clk_div.sv ====
`timescale 1ns/1ps
// divides the high source by the gear, or passes the low source undivided, into the system clock enable
module rsi_clk_div
	import rsi_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// source ticks
	input  wire logic         high_freq_tick,
	input  wire logic         low_freq_tick,
	// configuration
	input  wire rsi_pkg::rsi_clk_cfg_t cfg,
	// result
	output logic              system_clock
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
	} rsi_div_state_t;

	rsi_div_state_t s_q, s_d;
	logic           selected_source_clock;

	// divisor limit from gear code; reserved codes act as divide by 16
	function automatic logic [3:0] gear_limit(input logic [2:0] g);
		case (g)
			GEAR_DIV1:  gear_limit = 4'h0;
			GEAR_DIV2:  gear_limit = 4'h1;
			GEAR_DIV4:  gear_limit = 4'h3;
			GEAR_DIV8:  gear_limit = 4'h7;
			GEAR_DIV16: gear_limit = 4'hF;
			default:    gear_limit = 4'hF;
		endcase
	endfunction

	// low source is used undivided
	assign selected_source_clock = cfg.sys_clock_select ? low_freq_tick : high_freq_tick; // see R17

	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (selected_source_clock) begin
			if (cfg.sys_clock_select || s_q.cnt >= gear_limit(cfg.clock_gear_field)) begin
				s_d.cnt  = DIV_CNT_RESET;
				s_d.tick = 1'b1; // see R17
			end else begin
				s_d.cnt = s_q.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign system_clock = s_q.tick;
endmodule

// ==== rtl/rsi_reset_init.sv ====
`timescale 1ns/1ps
// Function
// R1 - source holds reset low ten clocks
// R2 - system clock is high clock over two
// R3 - program counter loads from three vector bytes
// R4 - stack pointer set to 100H
// R5 - interrupt mask level set to seven
// R6 - addressing mode bit set to one
// R7 - register bank pointer cleared to zero
// R8 - fetch starts at vector, others kept
// R9 - working memory untouched by reset
// R10 - peripheral control registers return to defaults
// R11 - all ports revert to general purpose
// R12 - address latch strobe floats during reset
// R13 - software reprograms stack pointer itself
// R14 - nmi on falling or both edges
// R15 - board ties mode straps high
// R16 - single and dual clock modes
// R17 - system clock divides selected source; code divides only the high source, low source passes undivided
// R18 - software can drop pull-ups except reset
// R19 - gear codes select divide 1 to 16
// R20 - reset synchronised and counted before acceptance
module rsi_reset_init
	import rsi_pkg::*;
#(
	parameter int PORT_W = 8,
	parameter int CTRL_W = 8
) (
	// clock and power-on reset
	input  wire logic                      clk,
	input  wire logic                      rstn,
	// external reset pin, active low
	input  wire logic                      ext_reset_n,
	// oscillator ticks
	input  wire logic                      high_freq_tick,
	input  wire logic                      low_freq_tick,
	input  wire logic                      low_osc_enable,
	// software clock and pin configuration
	input  wire rsi_pkg::rsi_clk_cfg_t     clk_cfg_wdata,
	input  wire logic                      clk_cfg_we,
	input  wire logic                      pullup_disable,
	input  wire logic [CTRL_W-1:0]         periph_ctrl_wdata,
	input  wire logic                      periph_ctrl_we,
	input  wire logic [PORT_W-1:0]         port_func_wdata,
	input  wire logic                      port_func_we,
	// nmi
	input  wire logic                      nmi_pin,
	input  wire rsi_pkg::rsi_nmi_mode_t    nmi_mode,
	// vector fetch from memory, one byte per cycle
	output logic [23:0]                    vec_addr,
	output logic                           vec_rd,
	input  wire logic [7:0]                vec_data,
	// straps
	input  wire logic [1:0]                mode_strap_pins,
	// core state out
	output logic [23:0]                    program_counter,
	output logic [31:0]                    ext_stack_pointer,
	output rsi_pkg::rsi_status_word_t      status_word,
	output logic                           fetch_start,
	output logic                           core_in_reset,
	// pins and clocks
	output logic                           ale_out,
	output logic                           ale_oe,
	output logic                           pullup_en,
	output logic [PORT_W-1:0]              port_func_sel,
	output logic [CTRL_W-1:0]              periph_ctrl,
	output logic                           system_clock,
	output logic                           nmi_req,
	output logic                           dual_clock_mode,
	output logic                           strap_fault
);
	import rsi_pkg::*;

	initial begin
		if (PORT_W < 1 || CTRL_W < 1) begin
			$error("rsi_reset_init: widths must be positive");
		end
	end

	typedef enum logic [2:0] {
		ST_RUN,
		ST_HOLD,
		ST_VEC0,
		ST_VEC1,
		ST_VEC2,
		ST_WAIT
	} rsi_state_t;

	typedef struct packed {
		logic                 sync1;
		logic                 sync2;
		logic [3:0]           low_cnt;
		rsi_state_t           st;
		logic [23:0]          pc;
		logic [31:0]          sp;
		rsi_status_word_t     sw;
		logic                 fetch;
		rsi_clk_cfg_t         cfg;
		logic [CTRL_W-1:0]    periph;
		logic [PORT_W-1:0]    portf;
		logic                 nmi_prev;
		logic                 nmi_req;
		logic                 strap_bad;
		logic                 ale;
	} rsi_state_s_t;

	rsi_state_s_t s_q, s_d;
	logic         accepted;

	// low count reaching the minimum accepts reset
	assign accepted = (s_q.low_cnt == 4'(RST_MIN_CYC)); // see R20

	always_comb begin
		s_d          = s_q;
		s_d.fetch    = 1'b0;
		s_d.nmi_req  = 1'b0;
		// two-stage synchroniser, only sync2 is looked at
		s_d.sync1    = ext_reset_n;
		s_d.sync2    = s_q.sync1;
		// count consecutive low samples; a short glitch never resets the core
		if (s_q.sync2) begin
			s_d.low_cnt = 4'h0;
		end else if (!accepted) begin
			s_d.low_cnt = s_q.low_cnt + 4'h1; // see R1
		end
		s_d.nmi_prev = nmi_pin;
		// falling edge always; rising edge only in both-edge mode
		if ((s_q.nmi_prev && !nmi_pin) ||
		    (nmi_mode == RSI_NMI_BOTH && !s_q.nmi_prev && nmi_pin)) begin
			s_d.nmi_req = 1'b1; // see R14
		end
		if (clk_cfg_we && s_q.st == ST_RUN) begin
			s_d.cfg = clk_cfg_wdata; // see R19
		end
		if (periph_ctrl_we && s_q.st == ST_RUN) begin
			s_d.periph = periph_ctrl_wdata;
		end
		if (port_func_we && s_q.st == ST_RUN) begin
			s_d.portf = port_func_wdata;
		end
		case (s_q.st)
			ST_RUN: begin
				if (accepted) begin
					s_d.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// sw bits and io are forced while reset is held
				s_d.sp                  = SP_RESET;      // see R4
				s_d.sw.irq_mask_level   = MASK_RESET;    // see R5
				s_d.sw.max_mode         = MAXMODE_RESET; // see R6
				s_d.sw.reg_bank_pointer = BANK_RESET;    // see R7
				s_d.cfg.clock_gear_field = GEAR_RESET;   // see R2
				s_d.cfg.sys_clock_select = 1'b0;         // see R2
				s_d.periph              = '0;            // see R10
				s_d.portf               = '0;            // see R11
				s_d.strap_bad           = (mode_strap_pins != 2'b11); // see R15
				s_d.st                  = ST_VEC0;
			end
			ST_VEC0: begin
				s_d.pc[7:0] = vec_data; // see R3
				s_d.st      = ST_VEC1;
			end
			ST_VEC1: begin
				s_d.pc[15:8] = vec_data; // see R3
				s_d.st       = ST_VEC2;
			end
			ST_VEC2: begin
				s_d.pc[23:16] = vec_data; // see R3
				s_d.st        = ST_WAIT;
			end
			ST_WAIT: begin
				// start only after pin goes high again
				if (s_q.sync2) begin
					s_d.fetch = 1'b1; // see R8
					s_d.st    = ST_RUN;
				end
			end
			default: begin
				s_d.st = ST_HOLD;
			end
		endcase
		// a low still held at the minimum count during loading restarts the sequence
		if (s_q.st != ST_RUN && s_q.st != ST_HOLD && !s_q.sync2 && accepted) begin
			s_d.st = ST_HOLD;
		end
		// strobe floats from the very cycle reset is taken, not one later
		s_d.ale = (s_d.st == ST_RUN);
	end

	// only control state has reset values; no working memory lives here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q                     <= '0; // see R9
			s_q.sync1               <= 1'b1; // pin idles high, no false low count
			s_q.sync2               <= 1'b1;
			s_q.nmi_prev            <= 1'b1; // idle level, no false rising edge
			s_q.st                  <= ST_HOLD;
			s_q.sp                  <= SP_RESET;
			s_q.sw.irq_mask_level   <= MASK_RESET;
			s_q.sw.max_mode         <= MAXMODE_RESET;
			s_q.cfg.clock_gear_field <= GEAR_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	rsi_clk_div u_div (
		.clk            (clk),
		.rstn           (rstn),
		.high_freq_tick (high_freq_tick),
		.low_freq_tick  (low_freq_tick & low_osc_enable),
		.cfg            (s_q.cfg),
		.system_clock   (system_clock)
	);

	// vector address follows the load state
	always_comb begin
		vec_rd   = 1'b1;
		vec_addr = VEC_ADDR_LO;
		case (s_q.st)
			ST_VEC0: vec_addr = VEC_ADDR_LO;
			ST_VEC1: vec_addr = VEC_ADDR_MID;
			ST_VEC2: vec_addr = VEC_ADDR_HI;
			default: vec_rd   = 1'b0;
		endcase
	end

	assign program_counter   = s_q.pc;
	assign ext_stack_pointer = s_q.sp;
	assign status_word       = s_q.sw;
	assign fetch_start       = s_q.fetch;
	assign core_in_reset     = (s_q.st != ST_RUN);
	assign ale_out           = 1'b0;
	assign ale_oe            = s_q.ale; // see R12
	assign pullup_en         = !pullup_disable; // see R18
	assign port_func_sel     = s_q.portf;
	assign periph_ctrl       = s_q.periph;
	assign nmi_req           = s_q.nmi_req;
	assign dual_clock_mode   = low_osc_enable; // see R16
	assign strap_fault       = s_q.strap_bad;

	// the first low sample starts the property, nine more follow here
	sequence s_pin_low10;
		!s_q.sync2 [*8] ##1 !s_q.sync2;
	endsequence

	a_reset_accept: assert property (@(posedge clk) disable iff (!rstn) // see R20
		(s_q.st == ST_RUN && s_q.low_cnt == 4'h0 && !s_q.sync2) ##1 s_pin_low10
		|-> ##2 (s_q.st == ST_HOLD))
		else $error("reset not accepted after minimum low time");
	a_sp_value: assert property (@(posedge clk) disable iff (!rstn) // see R4
		(s_q.st == ST_HOLD) |=> (ext_stack_pointer == SP_RESET))
		else $error("stack pointer not set");
	a_mask_mode: assert property (@(posedge clk) disable iff (!rstn) // see R5
		(s_q.st == ST_HOLD) |=> (status_word.irq_mask_level == MASK_RESET
		&& status_word.max_mode == MAXMODE_RESET))
		else $error("mask or mode wrong");
	a_bank_zero: assert property (@(posedge clk) disable iff (!rstn) // see R7
		(s_q.st == ST_HOLD) |=> (status_word.reg_bank_pointer == BANK_RESET))
		else $error("bank not cleared");
	a_vec_load: assert property (@(posedge clk) disable iff (!rstn) // see R3
		(s_q.st == ST_VEC2) |=> (program_counter[23:16] == $past(vec_data)))
		else $error("pc high byte wrong");
	a_ale_float: assert property (@(posedge clk) disable iff (!rstn) // see R12
		(s_q.st == ST_VEC0) |=> !ale_oe [*2])
		else $error("strobe driven during reset");
	a_gear_reset: assert property (@(posedge clk) disable iff (!rstn) // see R2
		(s_q.st == ST_HOLD) |=> (s_q.cfg.clock_gear_field == GEAR_DIV2))
		else $error("clock not fc over two");
	a_nmi_fall: assert property (@(posedge clk) disable iff (!rstn) // see R14
		($fell(nmi_pin) && s_q.nmi_prev) |=> nmi_req)
		else $error("falling nmi edge missed");
	a_ports_gp: assert property (@(posedge clk) disable iff (!rstn) // see R11
		(s_q.st == ST_HOLD) |=> (port_func_sel == '0 && periph_ctrl == '0))
		else $error("ports not general purpose");

	// strobe, io lock, strap flag and fetch start around the load
	a_ale_reset: assert property (@(posedge clk) disable iff (!rstn) // see R12
		core_in_reset |-> !ale_oe)
		else $error("strobe driven while core held");
	a_io_locked: assert property (@(posedge clk) disable iff (!rstn) // see R10
		(core_in_reset && s_q.st != ST_HOLD)
		|=> ($stable(periph_ctrl) && $stable(port_func_sel)))
		else $error("io written while core held");
	a_strap_flag: assert property (@(posedge clk) disable iff (!rstn) // see R15
		(s_q.st == ST_HOLD) |=> (strap_fault == ($past(mode_strap_pins) != 2'h3)))
		else $error("strap flag wrong");
	a_fetch_go: assert property (@(posedge clk) disable iff (!rstn) // see R8
		(s_q.st == ST_WAIT && s_q.sync2) |=> (fetch_start && !core_in_reset && ale_oe))
		else $error("fetch did not start");

	// lower vector bytes land one cycle after their address shows
	a_vec_low: assert property (@(posedge clk) disable iff (!rstn) // see R3
		(s_q.st == ST_VEC0) |=> (program_counter[7:0] == $past(vec_data)))
		else $error("pc low byte wrong");
	a_vec_mid: assert property (@(posedge clk) disable iff (!rstn) // see R3
		(s_q.st == ST_VEC1) |=> (program_counter[15:8] == $past(vec_data)))
		else $error("pc middle byte wrong");

	// rising nmi edge counts only in both-edge mode
	a_nmi_both: assert property (@(posedge clk) disable iff (!rstn) // see R14
		(nmi_mode == RSI_NMI_BOTH && !s_q.nmi_prev && nmi_pin) |=> nmi_req)
		else $error("rising nmi edge missed");
	a_nmi_quiet: assert property (@(posedge clk) disable iff (!rstn) // see R14
		(nmi_mode == RSI_NMI_FALL && !(s_q.nmi_prev && !nmi_pin)) |=> !nmi_req)
		else $error("nmi request without falling edge");
endmodule

// ==== dv/rsi_reset_src.sv ====
`timescale 1ns/1ps
// external reset source, board straps and vector memory
module rsi_reset_src
	import rsi_pkg::*;
(
	// clock
	input  wire logic        clk,
	// vector to serve
	input  wire logic [23:0] vector,
	// memory side
	input  wire logic [23:0] vec_addr,
	input  wire logic        vec_rd,
	output logic [7:0]       vec_data,
	// pins
	output logic             ext_reset_n,
	output logic [1:0]       mode_strap_pins
);
	import rsi_pkg::*;
	logic [7:0] last_q;

	// board straps both high
	assign mode_strap_pins = 2'h3;
	initial ext_reset_n = 1'b1;

	// undriven data shows the inverse of the last byte, not a stale copy
	always_comb begin
		vec_data = ~last_q;
		if (vec_rd && vec_addr == VEC_ADDR_LO) vec_data = vector[7:0];
		if (vec_rd && vec_addr == VEC_ADDR_MID) vec_data = vector[15:8];
		if (vec_rd && vec_addr == VEC_ADDR_HI) vec_data = vector[23:16];
	end
	always_ff @(posedge clk) last_q <= vec_data;

	// low for n cycles; callers give 10 or more unless testing a refusal
	task automatic hold_low(input int n);
		@(posedge clk);
		ext_reset_n <= 1'b0;
		repeat (n) @(posedge clk);
		ext_reset_n <= 1'b1;
	endtask
endmodule

// ==== dv/cpu_reset_init_sequence_test.sv ====
`timescale 1ns/1ps
module cpu_reset_init_sequence_test;
	import rsi_pkg::*;
	logic clk = 0, rstn = 0, high_freq_tick = 1, low_freq_tick = 0, low_osc_enable = 0;
	logic clk_cfg_we = 0, pullup_disable = 0, periph_ctrl_we = 0, port_func_we = 0, nmi_pin = 1;
	logic [7:0] periph_ctrl_wdata = 0, port_func_wdata = 0, vec_data, port_func_sel, periph_ctrl;
	rsi_clk_cfg_t clk_cfg_wdata = '0;
	rsi_nmi_mode_t nmi_mode = RSI_NMI_FALL;
	rsi_status_word_t status_word;
	logic [23:0] vec_addr, program_counter, vector;
	logic [31:0] ext_stack_pointer;
	logic [1:0] mode_strap_pins;
	logic vec_rd, fetch_start, core_in_reset, ale_out, ale_oe, pullup_en, system_clock;
	logic nmi_req, dual_clock_mode, strap_fault, ext_reset_n;
	int mismatches = 0, comparisons = 0, seed = 32'hd72204c3, n, lf = 0;
	logic [7:0] d;
	byte unsigned vq[$];

	always #12.5 clk = ~clk;
	// slow source ticks once every four cycles
	always @(posedge clk) begin
		lf <= lf + 1;
		low_freq_tick <= (lf[1:0] == 2'h3);
	end

	rsi_reset_init u_dut (.clk(clk), .rstn(rstn), .ext_reset_n(ext_reset_n),
		.high_freq_tick(high_freq_tick), .low_freq_tick(low_freq_tick),
		.low_osc_enable(low_osc_enable), .clk_cfg_wdata(clk_cfg_wdata),
		.clk_cfg_we(clk_cfg_we), .pullup_disable(pullup_disable),
		.periph_ctrl_wdata(periph_ctrl_wdata), .periph_ctrl_we(periph_ctrl_we),
		.port_func_wdata(port_func_wdata), .port_func_we(port_func_we), .nmi_pin(nmi_pin),
		.nmi_mode(nmi_mode), .vec_addr(vec_addr), .vec_rd(vec_rd), .vec_data(vec_data),
		.mode_strap_pins(mode_strap_pins), .program_counter(program_counter),
		.ext_stack_pointer(ext_stack_pointer), .status_word(status_word),
		.fetch_start(fetch_start), .core_in_reset(core_in_reset), .ale_out(ale_out),
		.ale_oe(ale_oe), .pullup_en(pullup_en), .port_func_sel(port_func_sel),
		.periph_ctrl(periph_ctrl), .system_clock(system_clock), .nmi_req(nmi_req),
		.dual_clock_mode(dual_clock_mode), .strap_fault(strap_fault));
	rsi_reset_src u_src (.clk(clk), .vector(vector), .vec_addr(vec_addr), .vec_rd(vec_rd),
		.vec_data(vec_data), .ext_reset_n(ext_reset_n), .mode_strap_pins(mode_strap_pins));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// bounded wait: 0 for fetch start, 1 for reset held
	task automatic wait_for(input int sel);
		repeat (100) begin
			@(posedge clk);
			#1;
			if ((sel ? core_in_reset : fetch_start) === 1'b1) return;
		end
		chk(0, 1);
	endtask

	// pulses over a 64 cycle window: 0 system clock, 1 nmi over 6 cycles
	task automatic count(input int sel, output int c);
		c = 0;
		repeat (sel ? 6 : 64) begin
			@(posedge clk);
			#1;
			if ((sel ? nmi_req : system_clock) === 1'b1) c++;
		end
	endtask

	// bench model of the core values after a vector load
	task automatic core_check();
		vq = {vector[7:0], vector[15:8], vector[23:16]};
		chk(program_counter, {vq[2], vq[1], vq[0]});
		chk(ext_stack_pointer, 32'h00000100);
		chk(status_word, {1'b1, 3'h7, 3'h0});
	endtask

	task automatic cfg(input logic s, input logic [2:0] g);
		@(posedge clk);
		clk_cfg_wdata <= {s, g};
		clk_cfg_we <= 1'b1;
		@(posedge clk);
		clk_cfg_we <= 1'b0;
		repeat (20) @(posedge clk);
	endtask

	initial begin
		vector = 24'($random(seed));
		#1 chk(ale_oe, 0);
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		wait_for(0);
		core_check();
		chk(strap_fault, 0);
		@(posedge clk);
		#1 chk({ale_oe, ale_out}, 2'h2);
		$display("test power_up done");
		// run-time writes, then a low too short to count
		d = 8'($random(seed)) | 8'h01;
		@(posedge clk);
		periph_ctrl_wdata <= d;
		port_func_wdata <= ~d;
		periph_ctrl_we <= 1'b1;
		port_func_we <= 1'b1;
		@(posedge clk);
		periph_ctrl_we <= 1'b0;
		port_func_we <= 1'b0;
		u_src.hold_low(9);
		repeat (20) @(posedge clk);
		#1 chk({periph_ctrl, port_func_sel}, {d, ~d});
		chk(core_in_reset, 0);
		$display("test short_low done");
		vector = 24'($random(seed));
		fork
			u_src.hold_low(14);
			begin
				wait_for(1);
				chk(ale_oe, 0);
				chk(status_word, {1'b1, 3'h7, 3'h0});
				// writes during the load must be refused
				repeat (2) @(posedge clk);
				periph_ctrl_we <= 1'b1;
				port_func_we <= 1'b1;
				repeat (3) @(posedge clk);
				periph_ctrl_we <= 1'b0;
				port_func_we <= 1'b0;
			end
		join
		wait_for(0);
		core_check();
		chk({periph_ctrl, port_func_sel}, 16'h0000);
		$display("test accepted_reset done");
		count(0, n);
		chk(n, 32);
		// gear codes 0 to 5, reserved code 5 acts as divide by 16
		for (int g = 0; g < 6; g++) begin
			cfg(1'b0, 3'(g));
			count(0, n);
			chk(n, 64 >> (g > 4 ? 4 : g));
		end
		@(posedge clk);
		low_osc_enable <= 1'b1;
		cfg(1'b1, 3'h1);
		count(0, n);
		chk(n, 16);
		chk(dual_clock_mode, 1);
		$display("test clocks done");
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			nmi_mode <= rsi_nmi_mode_t'(m);
			pullup_disable <= m[0];
			repeat (4) @(posedge clk);
			#1 chk(pullup_en, !m[0]);
			@(posedge clk);
			nmi_pin <= 1'b0;
			count(1, n);
			chk(n, 1);
			@(posedge clk);
			nmi_pin <= 1'b1;
			count(1, n);
			chk(n, m);
		end
		$display("test nmi_pullup done");
		tally_and_finish();
	end

	// watchdog sized well above the roughly 800 cycles of the tests
	initial begin
		#(25 * 6000);
		mismatches++;
		tally_and_finish();
	end
endmodule
